// >>> core/ppc_core.sv
// Parallel port control core: registers, master transfer sequencer, slave buffer.
// Assumes the register port master of the house and asynchronous host pins.
// Contract
// - Disabled port hands every assigned pin back to general-purpose I/O.
// - Disable aborts active or queued transfers and clears busy.
// - Disabled port keeps all register contents, status flags included.
// - Enable resets buffer control logic and clears the status register.
// - Master busy flag is set while a transaction runs, clear otherwise.
// - Mode register selects master or slave and holds options.
// - Address register supplies address and chip selects in master only; chip_select_one and chip_select_two follow it in slave mode too.
// - Slave output data register is used only in slave operation.
// - Master input data register holds both read and write data.
// - Slave input data register captures host-strobed data.
// - Pin allocation bits grant address or chip-select pins to the port.
// - Status reports full, overflow, empty, underflow and per-buffer flags.
// - Port drives up to sixteen software-controlled address lines.
// - Port provides up to two chip-select outputs.
// - Strobes are separate read/write, or direction plus enable.
// - Data path supports eight and sixteen bit width.
// - Active level of the read, write and chip-select outputs is software selectable; host inputs are fixed active high.
// - Enhanced slave uses the two host address bits to index a four-byte buffer.
// - Legacy slave lets the host read and write one data register.
// - Freeze option halts operation while the processor is debug halted.
// - Multiplex field selects one of four address/data arrangements.
// - Chip-select field picks address bits, one or two selects.
// - Clear, set and invert aliases at offsets 4, 8 and C.
module ppc_core
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// Debug
	input  wire logic        debug_halt,
	// Data lines
	input  wire logic [15:0] port_data_lines_in,
	output logic      [15:0] port_data_lines_out,
	output logic      [15:0] port_data_lines_oe,
	// Address lines and chip selects
	output logic      [15:0] port_address_lines,
	output logic      [15:0] port_address_oe,
	output logic             chip_select_one,
	output logic             chip_select_two,
	// Strobes, driven in master and sensed in slave
	output logic             read_strobe,
	output logic             write_strobe,
	output logic             strobe_oe,
	input  wire logic        host_read_in,
	input  wire logic        host_write_in,
	input  wire logic        host_select_in,
	input  wire logic [1:0]  host_addr_in,
	// Level of the port enable, in master and slave mode alike
	output logic             port_active
);

	// ----------------------------------------------------------------
	// Register decode
	// ----------------------------------------------------------------
	logic [31:0] control_q;
	logic [31:0] mode_q;
	logic [31:0] target_q;
	logic [31:0] pins_q;
	logic [31:0] out_buf_q;
	logic [31:0] in_buf_q;
	logic [15:0] stat_q;
	logic [1:0]  alias_code;
	logic [7:0]  base_addr;
	logic        wr_control;
	logic        wr_mode;
	logic        wr_target;
	logic        wr_pins;
	logic        wr_out;
	logic        wr_in;
	logic        wr_start;
	logic        enabled;
	logic        frozen;
	logic        master;
	logic [1:0]  mode_sel;

	assign alias_code = reg_addr[3:2];
	assign base_addr  = reg_addr & ~{4'h0, ppc_pkg::ALIAS_MASK};
	assign wr_control = reg_wr && base_addr == ppc_pkg::PORT_CONTROL_OFS;
	assign wr_mode    = reg_wr && base_addr == ppc_pkg::PORT_MODE_OFS;
	assign wr_target  = reg_wr && base_addr == ppc_pkg::TARGET_ADDRESS_OFS;
	assign wr_pins    = reg_wr && base_addr == ppc_pkg::PIN_ALLOCATION_OFS;
	assign wr_out     = reg_wr && base_addr == ppc_pkg::SLAVE_OUTPUT_BUFFER_OFS;
	assign wr_in      = reg_wr && base_addr == ppc_pkg::DATA_HOLDING_INPUT_OFS;
	assign wr_start   = reg_wr && reg_addr == ppc_pkg::TRANSFER_START_OFS;

	assign enabled  = control_q[ppc_pkg::CTL_ENABLE];
	assign frozen   = control_q[ppc_pkg::CTL_FREEZE] && debug_halt;
	assign mode_sel = mode_q[ppc_pkg::MODE_SEL_LO +: 2];
	assign master   = mode_sel[1];

	// Alias arithmetic shared by the hand-built registers.
	function automatic logic [31:0] alias_apply(input logic [31:0] cur, input logic [1:0] code,
		input logic [31:0] wd, input logic [31:0] mask);
		logic [31:0] m;
		m = wd & mask;
		case (code)
			ppc_pkg::ALIAS_PLAIN: alias_apply = (cur & ~mask) | m;
			ppc_pkg::ALIAS_CLR:   alias_apply = cur & ~m;
			ppc_pkg::ALIAS_SET:   alias_apply = cur | m;
			default:              alias_apply = cur ^ m;
		endcase
	endfunction

	ppc_alias_reg #(.MASK(ppc_pkg::CONTROL_MASK)) u_control
	(
		.clk        (clk),
		.reset      (reset),
		.wr         (wr_control),
		.alias_code (alias_code),
		.wdata      (reg_wdata),
		.value_q    (control_q)
	);

	ppc_alias_reg #(.MASK(ppc_pkg::ADDR_MASK)) u_target
	(
		.clk        (clk),
		.reset      (reset),
		.wr         (wr_target),
		.alias_code (alias_code),
		.wdata      (reg_wdata),
		.value_q    (target_q)
	);

	ppc_alias_reg #(.MASK(ppc_pkg::PINS_MASK)) u_pins
	(
		.clk        (clk),
		.reset      (reset),
		.wr         (wr_pins),
		.alias_code (alias_code),
		.wdata      (reg_wdata),
		.value_q    (pins_q)
	);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [15:0] data_sync;
	logic [4:0]  host_sync;
	logic        host_rd_q;
	logic        host_wr_q;
	logic        host_rd_rise;
	logic        host_wr_rise;

	ppc_sync #(.WIDTH(16)) u_data_sync
	(
		.clk      (clk),
		.reset    (reset),
		.async_in (port_data_lines_in),
		.sync_q   (data_sync)
	);

	ppc_sync #(.WIDTH(5)) u_host_sync
	(
		.clk      (clk),
		.reset    (reset),
		.async_in ({host_addr_in, host_select_in, host_write_in, host_read_in}),
		.sync_q   (host_sync)
	);

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			host_rd_q <= 1'b0;
			host_wr_q <= 1'b0;
		end
		else
		begin
			host_rd_q <= host_sync[0];
			host_wr_q <= host_sync[1];
		end
	end

	// Host strobes are sensed active high, with no polarity correction.
	assign host_rd_rise = host_sync[2] && host_sync[0] && !host_rd_q;
	assign host_wr_rise = host_sync[2] && host_sync[1] && !host_wr_q;

	// ----------------------------------------------------------------
	// Master sequencer
	// ----------------------------------------------------------------
	ppc_pkg::ppc_state_type state_q;
	logic                   dir_read_q;
	logic [1:0]             cnt_q;
	logic                   busy;
	logic                   slave_ev;

	assign busy = state_q != ppc_pkg::PPC_IDLE;

	// Writing one to bit 0 of the start word reads, zero writes, from the holding register.
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			state_q    <= ppc_pkg::PPC_IDLE;
			dir_read_q <= 1'b0;
			cnt_q      <= 2'h0;
		end
		else if (!enabled)
			state_q <= ppc_pkg::PPC_IDLE;
		else if (!frozen)
		begin
			case (state_q)
				ppc_pkg::PPC_IDLE:
					if (wr_start && master)
					begin
						dir_read_q <= reg_wdata[0];
						state_q    <= ppc_pkg::PPC_ADDR;
					end
				ppc_pkg::PPC_ADDR:
				begin
					cnt_q   <= 2'h0;
					state_q <= ppc_pkg::PPC_STROBE;
				end
				ppc_pkg::PPC_STROBE:
				begin
					cnt_q <= cnt_q + 2'h1;
					if (cnt_q == 2'(ppc_pkg::STROBE_CYCLES - 1))
						state_q <= ppc_pkg::PPC_DONE;
				end
				default:
					state_q <= ppc_pkg::PPC_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Mode register with hardware busy bit
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			mode_q <= ppc_pkg::REG_RESET;
		else
		begin
			if (wr_mode)
				mode_q <= alias_apply(mode_q, alias_code, reg_wdata, ppc_pkg::MODE_MASK);
			mode_q[ppc_pkg::MODE_BUSY] <= busy;
		end
	end

	// ----------------------------------------------------------------
	// Data registers and slave buffer
	// ----------------------------------------------------------------
	logic [15:0] data_mask;
	logic        stat_clear;
	logic [1:0]  host_idx;
	logic [15:0] stat_d;

	assign data_mask  = mode_q[ppc_pkg::MODE_WIDTH16] ? 16'hFFFF : 16'h00FF;
	assign stat_clear = wr_control && enabled == 1'b0 && alias_code != ppc_pkg::ALIAS_CLR
		&& reg_wdata[ppc_pkg::CTL_ENABLE];
	assign slave_ev   = enabled && !master && !frozen;
	assign host_idx   = (mode_sel == ppc_pkg::MODE_BUF_SLAVE) ? host_sync[4:3] : 2'h0;

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			in_buf_q <= ppc_pkg::REG_RESET;
		else if (master && state_q == ppc_pkg::PPC_DONE && dir_read_q && enabled)
			in_buf_q <= {16'h0, data_sync & data_mask};
		else if (slave_ev && host_wr_rise)
			in_buf_q[host_idx*8 +: 8] <= data_sync[7:0];
		else if (wr_in)
			in_buf_q <= alias_apply(in_buf_q, alias_code, reg_wdata, 32'hFFFF_FFFF);
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			out_buf_q <= ppc_pkg::REG_RESET;
		else if (wr_out)
			out_buf_q <= alias_apply(out_buf_q, alias_code, reg_wdata, 32'hFFFF_FFFF);
	end

	// Per-byte flags: input full bits 11:8, output empty bits 3:0.
	always_comb
	begin
		stat_d = stat_q;
		if (reg_wr && base_addr == ppc_pkg::SLAVE_BUFFER_STATUS_OFS)
			stat_d = 16'(alias_apply({16'h0, stat_q}, alias_code, reg_wdata,
				32'h0000_4040));
		// A read while disabled must not cost the host its full flags.
		if (enabled && reg_rd && reg_addr == ppc_pkg::DATA_HOLDING_INPUT_OFS && !master)
			stat_d[11:8] = 4'h0;
		if (wr_out && !master)
			stat_d[3:0] = 4'h0;
		if (slave_ev && host_wr_rise)
		begin
			if (stat_q[8 + host_idx])
				stat_d[ppc_pkg::STAT_INPUT_OVERFLOW] = 1'b1;
			stat_d[8 + host_idx] = 1'b1;
		end
		if (slave_ev && host_rd_rise)
		begin
			if (stat_q[host_idx])
				stat_d[ppc_pkg::STAT_OUTPUT_UNDERFLOW] = 1'b1;
			stat_d[host_idx] = 1'b1;
		end
		stat_d[ppc_pkg::STAT_IBF] = (mode_sel == ppc_pkg::MODE_BUF_SLAVE) ? &stat_d[11:8]
			: stat_d[8];
		stat_d[ppc_pkg::STAT_OBE] = (mode_sel == ppc_pkg::MODE_BUF_SLAVE) ? &stat_d[3:0]
			: stat_d[0];
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			stat_q <= 16'h0;
		else if (stat_clear)
			stat_q <= 16'h0;
		else
			stat_q <= stat_d;
	end

	// ----------------------------------------------------------------
	// Pin drive
	// ----------------------------------------------------------------
	logic [1:0]  mux_sel;
	logic [1:0]  chip_select_function;
	logic [15:0] addr_val;
	logic        addr_phase;
	logic        strobe_on;
	logic        cs1_act;
	logic        cs2_act;

	assign mux_sel    = control_q[ppc_pkg::CTL_MUX_LO +: 2];
	assign chip_select_function        = control_q[ppc_pkg::CTL_CSF_LO +: 2];
	assign addr_val   = target_q[15:0];
	assign addr_phase = state_q == ppc_pkg::PPC_ADDR;
	assign strobe_on  = state_q == ppc_pkg::PPC_STROBE;
	assign port_active = enabled;
	assign cs1_act    = chip_select_function == ppc_pkg::CSF_TWO_CS ? addr_val[14] : 1'b0;
	assign cs2_act    = chip_select_function != ppc_pkg::CSF_ADDR ? addr_val[15] : 1'b0;

	always_comb
	begin
		port_address_lines  = addr_val;
		port_address_oe     = (enabled && master) ? pins_q[15:0] : 16'h0;
		chip_select_one     = (chip_select_function == ppc_pkg::CSF_TWO_CS)
			? (cs1_act == control_q[ppc_pkg::CTL_CS1_POL]) : addr_val[14];
		chip_select_two     = (chip_select_function != ppc_pkg::CSF_ADDR)
			? (cs2_act == control_q[ppc_pkg::CTL_CS2_POL]) : addr_val[15];
		port_data_lines_out = master ? (in_buf_q[15:0] & data_mask)
			: (host_idx == 2'h0 ? {8'h0, out_buf_q[7:0]} : {8'h0, out_buf_q[host_idx*8 +: 8]});
		port_data_lines_oe  = 16'h0;
		if (enabled && master && addr_phase)
		begin
			case (mux_sel)
				ppc_pkg::MUX_LOW_BYTE: port_data_lines_out = {8'h0, addr_val[7:0]};
				ppc_pkg::MUX_FULL_8:   port_data_lines_out = {8'h0, addr_val[7:0]};
				ppc_pkg::MUX_FULL_16:  port_data_lines_out = addr_val;
				default:               port_data_lines_out = 16'h0;
			endcase
			port_data_lines_oe = (mux_sel == ppc_pkg::MUX_SEPARATE) ? 16'h0
				: (mux_sel == ppc_pkg::MUX_FULL_16 ? 16'hFFFF : 16'h00FF);
		end
		else if (enabled && master && !dir_read_q && busy)
			port_data_lines_oe = data_mask;
		else if (enabled && !master && host_sync[2] && host_sync[0])
			port_data_lines_oe = 16'h00FF;
		if (mode_sel == ppc_pkg::MODE_MASTER1)
		begin
			read_strobe  = (strobe_on ? dir_read_q : 1'b0) == control_q[ppc_pkg::CTL_RD_POL];
			write_strobe = strobe_on == control_q[ppc_pkg::CTL_WR_POL];
		end
		else
		begin
			read_strobe  = (strobe_on && dir_read_q) == control_q[ppc_pkg::CTL_RD_POL];
			write_strobe = (strobe_on && !dir_read_q) == control_q[ppc_pkg::CTL_WR_POL];
		end
		strobe_oe = enabled && master
			&& (control_q[ppc_pkg::CTL_RD_EN] || control_q[ppc_pkg::CTL_WR_EN]);
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			reg_rdata <= 32'h0;
		else if (!reg_rd)
			reg_rdata <= 32'h0;
		else if (reg_addr == ppc_pkg::PORT_CONTROL_OFS)
			reg_rdata <= control_q;
		else if (reg_addr == ppc_pkg::PORT_MODE_OFS)
			reg_rdata <= mode_q;
		else if (reg_addr == ppc_pkg::TARGET_ADDRESS_OFS)
			reg_rdata <= target_q;
		else if (reg_addr == ppc_pkg::SLAVE_OUTPUT_BUFFER_OFS)
			reg_rdata <= out_buf_q;
		else if (reg_addr == ppc_pkg::DATA_HOLDING_INPUT_OFS)
			reg_rdata <= in_buf_q;
		else if (reg_addr == ppc_pkg::PIN_ALLOCATION_OFS)
			reg_rdata <= pins_q;
		else if (reg_addr == ppc_pkg::SLAVE_BUFFER_STATUS_OFS)
			reg_rdata <= {16'h0, stat_q};
		else
			reg_rdata <= 32'h0;
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	busy_cleared_a: assert property (@(posedge clk) disable iff (reset)
		!enabled |=> state_q == ppc_pkg::PPC_IDLE) else $error("busy not cleared on disable");
	busy_flag_a: assert property (@(posedge clk) disable iff (reset)
		busy |=> mode_q[ppc_pkg::MODE_BUSY]) else $error("busy flag lags transfer");
	pins_released_a: assert property (@(posedge clk) disable iff (reset)
		!enabled |-> port_address_oe == 16'h0 && !strobe_oe) else $error("pins held while off");
	transfer_len_a: assert property (@(posedge clk) disable iff (reset)
		$rose(busy) && enabled && !frozen |-> ##[3:4] !busy || frozen || !enabled)
		else $error("transfer length wrong");
	status_kept_a: assert property (@(posedge clk) disable iff (reset)
		!enabled && !reg_wr |=> stat_q == $past(stat_q)) else $error("status lost while off");
	enable_clear_a: assert property (@(posedge clk) disable iff (reset)
		stat_clear |=> stat_q == 16'h0) else $error("status not cleared on enable");
	overflow_set_a: assert property (@(posedge clk) disable iff (reset)
		slave_ev && host_wr_rise && stat_q[8 + host_idx] && !stat_clear
		|=> stat_q[ppc_pkg::STAT_INPUT_OVERFLOW]) else $error("overflow missed");
	grant_map_a: assert property (@(posedge clk) disable iff (reset)
		enabled && master |-> port_address_oe == pins_q[15:0]) else $error("grant mismatch");
	freeze_hold_a: assert property (@(posedge clk) disable iff (reset)
		frozen && enabled && busy |=> state_q == $past(state_q)) else $error("ran while frozen");

	master_write_c: cover property (@(posedge clk) disable iff (reset)
		$rose(busy) && !dir_read_q ##[1:6] !busy);
	master_read_c: cover property (@(posedge clk) disable iff (reset)
		state_q == ppc_pkg::PPC_DONE && dir_read_q);
	slave_full_c: cover property (@(posedge clk) disable iff (reset) stat_q[ppc_pkg::STAT_IBF]);
	abort_c: cover property (@(posedge clk) disable iff (reset) busy ##1 !enabled);

endmodule

// >>> core/ppc_pkg.sv
// Constants, register map and field layout of the parallel port control core.
// Assumes a word-addressed register port with byte offsets on a 32-bit bus.
package ppc_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] PORT_CONTROL_OFS        = 8'h00;
	localparam logic [7:0] PORT_MODE_OFS           = 8'h10;
	localparam logic [7:0] TARGET_ADDRESS_OFS      = 8'h20;
	localparam logic [7:0] SLAVE_OUTPUT_BUFFER_OFS = 8'h30;
	localparam logic [7:0] DATA_HOLDING_INPUT_OFS  = 8'h40;
	localparam logic [7:0] PIN_ALLOCATION_OFS      = 8'h50;
	localparam logic [7:0] SLAVE_BUFFER_STATUS_OFS = 8'h60;
	localparam logic [7:0] TRANSFER_START_OFS      = 8'h70;
	localparam logic [3:0] ALIAS_MASK              = 4'hC;
	localparam logic [1:0] ALIAS_PLAIN             = 2'h0;
	localparam logic [1:0] ALIAS_CLR               = 2'h1;
	localparam logic [1:0] ALIAS_SET               = 2'h2;
	localparam logic [1:0] ALIAS_INV               = 2'h3;

	// ----------------------------------------------------------------
	// Writable bit masks and reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] CONTROL_MASK = 32'h0000_BFFB;
	localparam logic [31:0] MODE_MASK    = 32'h0000_7FFF;
	localparam logic [31:0] ADDR_MASK    = 32'h0000_FFFF;
	localparam logic [31:0] PINS_MASK    = 32'h0000_FFFF;
	localparam logic [31:0] REG_RESET    = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTL_ENABLE    = 15;
	localparam int CTL_FREEZE    = 13;
	localparam int CTL_MUX_LO    = 11;
	localparam int CTL_WR_EN     = 9;
	localparam int CTL_RD_EN     = 8;
	localparam int CTL_CSF_LO    = 6;
	localparam int CTL_CS2_POL   = 4;
	localparam int CTL_CS1_POL   = 3;
	localparam int CTL_WR_POL    = 1;
	localparam int CTL_RD_POL    = 0;
	localparam int MODE_BUSY     = 15;
	localparam int MODE_WIDTH16  = 10;
	localparam int MODE_SEL_LO   = 8;
	localparam int STAT_IBF      = 15;
	localparam int STAT_INPUT_OVERFLOW     = 14;
	localparam int STAT_OBE      = 7;
	localparam int STAT_OUTPUT_UNDERFLOW     = 6;

	// ----------------------------------------------------------------
	// Encodings
	// ----------------------------------------------------------------
	localparam logic [1:0] MODE_LEGACY_SLAVE = 2'h0;
	localparam logic [1:0] MODE_BUF_SLAVE    = 2'h1;
	localparam logic [1:0] MODE_MASTER2      = 2'h2;
	localparam logic [1:0] MODE_MASTER1      = 2'h3;
	localparam logic [1:0] MUX_SEPARATE      = 2'h0;
	localparam logic [1:0] MUX_LOW_BYTE      = 2'h1;
	localparam logic [1:0] MUX_FULL_8        = 2'h2;
	localparam logic [1:0] MUX_FULL_16       = 2'h3;
	localparam logic [1:0] CSF_ADDR          = 2'h0;
	localparam logic [1:0] CSF_ONE_CS        = 2'h1;
	localparam logic [1:0] CSF_TWO_CS        = 2'h2;
	localparam int          STROBE_CYCLES    = 2;
	localparam int          BUF_DEPTH        = 4;

	typedef enum logic [1:0] {PPC_IDLE, PPC_ADDR, PPC_STROBE, PPC_DONE} ppc_state_type;

endpackage

// >>> core/ppc_alias_reg.sv
// One software register with plain, clear, set and invert write aliases.
// Assumes the parent decodes the alias code and the write strobe.
module ppc_alias_reg
#(
	parameter logic [31:0] MASK = 32'hFFFF_FFFF
)
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// Write access
	input  wire logic        wr,
	input  wire logic [1:0]  alias_code,
	input  wire logic [31:0] wdata,
	// Stored value
	output logic      [31:0] value_q
);

	logic [31:0] value_d;

	always_comb
	begin
		value_d = value_q;
		case (alias_code)
			ppc_pkg::ALIAS_PLAIN: value_d = wdata & MASK;
			ppc_pkg::ALIAS_CLR:   value_d = value_q & ~(wdata & MASK);
			ppc_pkg::ALIAS_SET:   value_d = value_q | (wdata & MASK);
			default:              value_d = value_q ^ (wdata & MASK);
		endcase
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			value_q <= ppc_pkg::REG_RESET;
		else if (wr)
			value_q <= value_d;
	end

endmodule

// >>> core/ppc_sync.sv
// Two-flop synchroniser for a bundle of pin inputs.
// Assumes the inputs are asynchronous to clk; only the second stage is read.
module ppc_sync
#(
	parameter int WIDTH = 1
)
(
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             reset,
	// Pins
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_q
);

	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			meta_q <= '0;
			sync_q <= '0;
		end
		else
		begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

endmodule

// >>> dv/ppc_periph.sv
// Model of the far side: a parallel peripheral or external host.
// Assumes the core samples the host pins through its own synchronisers.
module ppc_periph
(
	// Clock
	input  wire logic        clk,
	// Port side
	input  wire logic [15:0] data_oe,
	output logic      [15:0] data,
	output logic             hrd,
	output logic             hwr,
	output logic             hsel,
	output logic      [1:0]  haddr
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] drv = 16'h0000;
	logic [15:0] pat = 16'h5555;
	logic        drv_en = 1'b0;
	initial
	begin
		hrd = 1'b0;
		hwr = 1'b0;
		hsel = 1'b0;
		haddr = 2'h0;
	end
	// Released lines toggle every cycle so stale data never looks valid.
	always @(posedge clk) pat <= ~pat;
	assign data = (data_oe == 16'h0000 && drv_en) ? drv : pat;
	task automatic offer(input logic [15:0] v, input logic en);
		drv <= v;
		drv_en <= en;
	endtask
	// One host strobe on byte idx: a read when is_rd is set, a write of b otherwise.
	task automatic host_op(input logic is_rd, input logic [1:0] idx, input logic [7:0] b);
		@(posedge clk);
		drv <= {8'h00, b};
		drv_en <= 1'b1;
		haddr <= idx;
		hsel <= 1'b1;
		repeat (2) @(posedge clk);
		hrd <= is_rd;
		hwr <= !is_rd;
		repeat (4) @(posedge clk);
		hrd <= 1'b0;
		hwr <= 1'b0;
		repeat (4) @(posedge clk);
		hsel <= 1'b0;
		drv_en <= 1'b0;
	endtask
endmodule

// >>> dv/tb.sv
// Self-checking bench of the parallel port control core.
// Assumes the peripheral model answers on the data lines.
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, v;
	logic reg_wr = 1'b0, reg_rd = 1'b0;
	logic [15:0] d_in, d_oe, a_oe;
	logic hrd, hwr, hsel;
	logic [1:0] haddr;
	logic halt = 1'b0;
	logic [15:0] d_out, a_lines;
	logic rs, ws, sto, pact, cs1, cs2;
	int err_count = 0;
	int n_checks = 0;
	ppc_core DUT (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .debug_halt(halt),
		.port_data_lines_in(d_in), .port_data_lines_out(d_out), .port_data_lines_oe(d_oe),
		.port_address_lines(a_lines), .port_address_oe(a_oe), .chip_select_one(cs1),
		.chip_select_two(cs2), .read_strobe(rs), .write_strobe(ws), .strobe_oe(sto),
		.host_read_in(hrd), .host_write_in(hwr), .host_select_in(hsel),
		.host_addr_in(haddr), .port_active(pact));
	ppc_periph u_p (.clk(clk), .data_oe(d_oe), .data(d_in), .hrd(hrd), .hwr(hwr),
		.hsel(hsel), .haddr(haddr));
	initial
	begin
		forever #4 clk = ~clk;
	end
	// ----------------------------------------------------------------
	// Bus tasks
	// ----------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e)
		begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", n, e, s);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_regs;
		rd(8'h00);
		chk("control", v, 32'h0);
		chk("idle strobes", {rs, ws, sto}, 3'b110);
		wr(8'h50, 32'h00FF);
		wr(8'h58, 32'hFF00);
		wr(8'h54, 32'h000F);
		wr(8'h5C, 32'h00FF);
		rd(8'h50);
		chk("pins", v, 32'hFF0F);
		rd(8'h58);
		chk("alias read", v, 32'h0);
		rd(8'hF0);
		chk("unmapped", v, 32'h0);
		$display("regs done");
	endtask
	task automatic t_master;
		wr(8'h50, 32'h00FF);
		wr(8'h20, 32'h1234);
		wr(8'h10, 32'h0600);
		wr(8'h00, 32'h8303);
		// The enable lands with the edge that ends the write; look once it has settled.
		#1 chk("addr oe", a_oe, 16'h00FF);
		wr(8'h40, 32'hBEEF);
		wr(8'h70, 32'h0);
		rd(8'h10);
		chk("busy", v[15], 1'b1);
		chk("write pins", {d_oe, d_out}, 32'hFFFF_BEEF);
		chk("strobes", {rs, ws, sto, pact}, 4'b0111);
		chk("addr pins", {cs2, cs1, a_lines}, 18'h01234);
		repeat (8) @(posedge clk);
		rd(8'h10);
		chk("idle", v[15], 1'b0);
		u_p.offer(16'hA5C3, 1'b1);
		wr(8'h70, 32'h1);
		repeat (8) @(posedge clk);
		rd(8'h40);
		chk("read data", v[15:0], 16'hA5C3);
		wr(8'h08, 32'h2000);
		wr(8'h70, 32'h1);
		halt <= 1'b1;
		repeat (8) @(posedge clk);
		rd(8'h10);
		chk("frozen", v[15], 1'b1);
		@(posedge clk);
		halt <= 1'b0;
		repeat (8) @(posedge clk);
		rd(8'h10);
		chk("thawed", v[15], 1'b0);
		u_p.offer(16'h0000, 1'b0);
		wr(8'h70, 32'h0);
		wr(8'h04, 32'h8000);
		// The busy bit follows the sequencer one cycle later.
		@(posedge clk);
		rd(8'h10);
		chk("abort", v[15], 1'b0);
		chk("pins back", a_oe, 16'h0);
		rd(8'h20);
		chk("kept addr", v, 32'h1234);
		$display("master done");
	endtask
	task automatic t_slave;
		wr(8'h10, 32'h0100);
		wr(8'h08, 32'h8000);
		u_p.host_op(1'b0, 2'h1, 8'h3C);
		u_p.host_op(1'b0, 2'h2, 8'h5A);
		u_p.host_op(1'b0, 2'h2, 8'h5A);
		rd(8'h60);
		chk("status", v[15:0], 16'h4600);
		rd(8'h40);
		chk("in data", v[23:8], 16'h5A3C);
		wr(8'h04, 32'h8000);
		rd(8'h60);
		chk("kept stat", v[15:0], 16'h4000);
		wr(8'h08, 32'h8000);
		rd(8'h60);
		chk("clr stat", v[15:0], 16'h0000);
		wr(8'h30, 32'h4433_2211);
		u_p.host_op(1'b1, 2'h1, 8'h00);
		#1 chk("slave out", d_out, 16'h0022);
		u_p.host_op(1'b1, 2'h1, 8'h00);
		rd(8'h60);
		chk("underflow", v[15:0], 16'h0042);
		$display("slave done");
	endtask
	initial
	begin
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		t_regs;
		t_master;
		t_slave;
		stop_test;
	end
	initial
	begin
		#100000;
		err_count++;
		stop_test;
	end
endmodule
